// file: verilog/vme_out_pkg.sv
// Contract
// - Start table lookup when PCI address bits 31..29 equal the large window base.
// - Start table lookup when PCI address bits 31..26 equal the sparse window base.
// - Large window indexes the table with PCI address bits 28..18.
// - Sparse window indexes with bits 25..18, sharing the first 256 entries.
// - VME page from entry bits 31..18; PCI bits 17..2 and byte enables give offset.
// - Entry bit 5 clear blocks the VME cycle and sets the outbound error flag.
// - Error interrupt rises only while its enable bit is set.
// - Size field 01 A32, 11 A24, 10 A16, 00 takes user code register.
// - Modifier codes per size, function code, block and D64 as tabulated.
// - DMA turns the modifier into its block form, user codes unchanged; code also passes A16 codes through unchanged.
// - Locked entry keeps bus ownership through the next VME-bound PCI cycle.
// - Single transfers take D08, D16 or D32 size from byte enables.
// - Block engine moves up to 64 KB in D16, D32 or D64, splitting itself; code issues D32 or D64 only.
// - DMA splits into tenures at 256 B or 2 KB boundaries with optional wait.
// - Wait between tenures is 250 ns times control bits 3..0.
// - Control bit 4 selects read when set; bit 6 enables block mode.
// - Large window 2048 pages of 256 KB; sparse 256 pages reusing entries.
package vme_out_pkg;
  // ==========================================================
  // Register map
  localparam logic [13:0] OFF_LWB      = 14'h0000;
  localparam logic [13:0] OFF_SWB      = 14'h0004;
  localparam logic [13:0] OFF_ICR      = 14'h0008;
  localparam logic [13:0] OFF_AMSR     = 14'h000C;
  localparam logic [13:0] OFF_BESR     = 14'h0010;
  localparam logic [13:0] OFF_PIC      = 14'h0014;
  localparam logic [13:0] OFF_BTC      = 14'h0018;
  localparam logic [13:0] OFF_BDR      = 14'h001C;
  localparam logic [13:0] OFF_LEN_LO   = 14'h0020;
  localparam logic [13:0] OFF_LEN_HI   = 14'h0024;
  localparam logic [13:0] OFF_DIC      = 14'h0028;
  localparam logic [13:0] OFF_DSTAT    = 14'h002C;
  localparam logic [13:0] OFF_SG       = 14'h2000;
  localparam int          SG_ENTRIES   = 2048;
  // ==========================================================
  // Entry and register fields
  localparam int          E_VALID      = 5;
  localparam int          E_LOCK       = 4;
  localparam int          BTC_DIR      = 4;
  localparam int          BTC_EN       = 6;
  localparam int          BDR_D64      = 4;
  localparam int          BDR_X2K      = 7;
  localparam logic [2:0]  LOCK_ENABLE  = 3'h1;
  localparam logic [1:0]  AS_USER      = 2'h0;
  localparam logic [1:0]  AS_A32       = 2'h1;
  localparam logic [1:0]  AS_A16       = 2'h2;
  localparam logic [1:0]  AS_A24       = 2'h3;
  localparam logic [1:0]  DS_D08       = 2'h0;
  localparam logic [1:0]  DS_D16       = 2'h1;
  localparam logic [1:0]  DS_D32       = 2'h2;
  localparam logic [1:0]  DS_D64       = 2'h3;
  // ==========================================================
  // Modifier bases: single adds 0, 1, 4 or 5 by fc, block adds 3 or 7, D64 adds 0 or 4
  localparam logic [5:0]  AM_A32_BASE  = 6'h09;
  localparam logic [5:0]  AM_A32_BLK   = 6'h08;
  localparam logic [5:0]  AM_A24_BASE  = 6'h39;
  localparam logic [5:0]  AM_A24_BLK   = 6'h38;
  localparam logic [5:0]  AM_A16_USER  = 6'h29;
  localparam logic [5:0]  AM_A16_SUPV  = 6'h2D;
  // ==========================================================
  // Timing
  localparam int          ILV_UNIT_NS  = 250;
  localparam int          CLK_NS       = 10;
  localparam int          ILV_CYCLES   = (ILV_UNIT_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [12:0] TEN_SMALL    = 13'h0100;
  localparam logic [12:0] TEN_LARGE    = 13'h0800;

  typedef enum logic [3:0] {
    S_IDLE  = 4'b0001,
    S_ISSUE = 4'b0010,
    S_TEN   = 4'b0100,
    S_GAP   = 4'b1000
  } dma_state_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [5:0]  am;
    logic [1:0]  dsize;
    logic        write;
    logic        block;
    logic [15:0] len;
    logic [31:0] pci_addr;
  } vme_cmd_t;
endpackage

// file: verilog/vme_outbound_bridge.sv
`timescale 1ns/1ps
`default_nettype none
module vme_outbound_bridge (
  input  wire logic                CLK,
  input  wire logic                RST_N,
  input  wire logic [13:0]         REG_ADDR,
  input  wire logic [31:0]         REG_WDATA,
  input  wire logic                REG_WR,
  input  wire logic                REG_RD,
  output logic      [31:0]         REG_RDATA,
  input  wire logic                PCI_REQ,
  input  wire logic [31:0]         PCI_ADDR,
  input  wire logic [3:0]          PCI_BE,
  input  wire logic                PCI_WRITE,
  input  wire logic [31:0]         PCI_WDATA,
  output logic                     PCI_CLAIM,
  output logic                     PCI_ERR,
  output logic                     VME_START,
  output vme_out_pkg::vme_cmd_t    VME_CMD,
  input  wire logic                VME_DONE,
  output logic                     VME_HOLD,
  output logic                     ERR_IRQ,
  output logic                     DMA_IRQ,
  output logic                     DMA_BUSY
);
  // ==========================================================
  // Functions
  function automatic logic [5:0] am_of(input logic [1:0] asz, input logic [1:0] fc,
                                       input logic blk, input logic d64,
                                       input logic [5:0] user);
    logic [5:0] base;
    base = (asz == vme_out_pkg::AS_A32) ? vme_out_pkg::AM_A32_BLK : vme_out_pkg::AM_A24_BLK;
    case (asz)
      vme_out_pkg::AS_USER: am_of = user;
      vme_out_pkg::AS_A16:  am_of = fc[1] ? vme_out_pkg::AM_A16_SUPV : vme_out_pkg::AM_A16_USER;
      default: begin
        if (!blk)
          am_of = base + {3'h0, fc[1], 1'b0, fc[0]} + 6'h01;
        else if (d64)
          am_of = base + {3'h0, fc[1], 2'h0};
        else
          am_of = base + {3'h0, fc[1], 2'h3};
      end
    endcase
  endfunction
  function automatic logic [1:0] dsize_of(input logic [3:0] be);
    case (be)
      4'h1, 4'h2, 4'h4, 4'h8: dsize_of = vme_out_pkg::DS_D08;
      4'h3, 4'hC:             dsize_of = vme_out_pkg::DS_D16;
      default:                dsize_of = vme_out_pkg::DS_D32;
    endcase
  endfunction
  function automatic logic [1:0] boff_of(input logic [3:0] be);
    if (be[0])      boff_of = 2'h0;
    else if (be[1]) boff_of = 2'h1;
    else if (be[2]) boff_of = 2'h2;
    else            boff_of = 2'h3;
  endfunction
  // ==========================================================
  // Registers and table
  logic [31:0]  sg_mem [vme_out_pkg::SG_ENTRIES];
  logic [2:0]   lwb_r;
  logic [5:0]   swb_r;
  logic [7:0]   icr_r;
  logic [5:0]   amsr_r;
  logic         besr_err_r;
  logic         pic_en_r;
  logic [7:0]   btc_r;
  logic [7:0]   bdr_r;
  logic [7:0]   len_lo_r;
  logic [7:0]   len_hi_r;
  logic         dic_en_r;
  logic         dma_done_r;
  vme_out_pkg::dma_state_t state_r;
  logic [31:0]  dma_va_r;
  logic [31:0]  dma_pa_r;
  logic [15:0]  dma_rem_r;
  logic [5:0]   dma_am_r;
  logic         dma_rd_r;
  logic         dma_d64_r;
  logic         dma_big_r;
  logic [8:0]   gap_r;
  // ==========================================================
  // Window decode and lookup
  logic         hit1;
  logic         hit2;
  logic [10:0]  idx;
  logic [31:0]  entry;
  logic         take;
  logic         single_go;
  logic         dma_go;
  logic         dma_end;
  logic [31:0]  vaddr;
  logic [12:0]  room;
  logic [15:0]  chunk;
  logic         wr_besr;
  logic         wr_dstat;
  assign hit1  = PCI_ADDR[31:29] == lwb_r;
  assign hit2  = PCI_ADDR[31:26] == swb_r;
  assign idx   = hit1 ? PCI_ADDR[28:18] : {3'h0, PCI_ADDR[25:18]};
  assign entry = sg_mem[idx];
  assign take  = PCI_REQ && (hit1 || hit2) && (state_r == vme_out_pkg::S_IDLE);
  assign dma_go    = take && entry[vme_out_pkg::E_VALID] && PCI_WRITE
                     && btc_r[vme_out_pkg::BTC_EN];
  assign single_go = take && entry[vme_out_pkg::E_VALID] && !dma_go;
  assign vaddr = {entry[31:18], PCI_ADDR[17:2], boff_of(PCI_BE)};
  // Tenure never runs past the next 256 B or 2 KB line
  assign room  = dma_big_r ? vme_out_pkg::TEN_LARGE - {2'h0, dma_va_r[10:0]}
                           : vme_out_pkg::TEN_SMALL - {5'h0, dma_va_r[7:0]};
  assign chunk = (dma_rem_r < {3'h0, room}) ? dma_rem_r : {3'h0, room};
  assign dma_end  = (state_r == vme_out_pkg::S_ISSUE && dma_rem_r == 16'h0)
                 || (state_r == vme_out_pkg::S_TEN && VME_DONE && dma_rem_r == 16'h0);
  assign wr_besr  = REG_WR && REG_ADDR == vme_out_pkg::OFF_BESR;
  assign wr_dstat = REG_WR && REG_ADDR == vme_out_pkg::OFF_DSTAT;
  // ==========================================================
  // Register writes
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      lwb_r    <= 3'h0;
      swb_r    <= 6'h00;
      icr_r    <= 8'h00;
      amsr_r   <= 6'h00;
      pic_en_r <= 1'b0;
      btc_r    <= 8'h00;
      bdr_r    <= 8'h00;
      len_lo_r <= 8'h00;
      len_hi_r <= 8'h00;
      dic_en_r <= 1'b0;
    end else if (REG_WR) begin
      case (REG_ADDR)
        vme_out_pkg::OFF_LWB:    lwb_r    <= REG_WDATA[2:0];
        vme_out_pkg::OFF_SWB:    swb_r    <= REG_WDATA[5:0];
        vme_out_pkg::OFF_ICR:    icr_r    <= REG_WDATA[7:0];
        vme_out_pkg::OFF_AMSR:   amsr_r   <= REG_WDATA[5:0];
        vme_out_pkg::OFF_PIC:    pic_en_r <= REG_WDATA[0];
        vme_out_pkg::OFF_BTC:    btc_r    <= {1'b0, REG_WDATA[6], 1'b0, REG_WDATA[4:0]};
        vme_out_pkg::OFF_BDR:    bdr_r    <= REG_WDATA[7:0];
        vme_out_pkg::OFF_LEN_LO: len_lo_r <= REG_WDATA[7:0];
        vme_out_pkg::OFF_LEN_HI: len_hi_r <= REG_WDATA[7:0];
        vme_out_pkg::OFF_DIC:    dic_en_r <= REG_WDATA[0];
        default: ;
      endcase
    end
  end
  // Table has no reset; software fills it before opening a window
  always_ff @(posedge CLK) begin
    if (REG_WR && REG_ADDR[13] && REG_ADDR[1:0] == 2'h0)
      sg_mem[REG_ADDR[12:2]] <= REG_WDATA;
  end
  // Sticky flags: a new event beats a same-cycle clear
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      besr_err_r <= 1'b0;
      dma_done_r <= 1'b0;
    end else begin
      if (take && !entry[vme_out_pkg::E_VALID])
        besr_err_r <= 1'b1;
      else if (wr_besr && REG_WDATA[0])
        besr_err_r <= 1'b0;
      if (dma_end)
        dma_done_r <= 1'b1;
      else if (wr_dstat && REG_WDATA[0])
        dma_done_r <= 1'b0;
    end
  end
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      ERR_IRQ  <= 1'b0;
      DMA_IRQ  <= 1'b0;
      DMA_BUSY <= 1'b0;
    end else begin
      ERR_IRQ  <= besr_err_r && pic_en_r;
      DMA_IRQ  <= dma_done_r && dic_en_r;
      DMA_BUSY <= state_r != vme_out_pkg::S_IDLE;
    end
  end
  always_ff @(posedge CLK) begin
    if (!RST_N)
      REG_RDATA <= 32'h0;
    else if (!REG_RD)
      REG_RDATA <= 32'h0;
    else if (REG_ADDR[13])
      REG_RDATA <= sg_mem[REG_ADDR[12:2]];
    else begin
      case (REG_ADDR)
        vme_out_pkg::OFF_LWB:    REG_RDATA <= {29'h0, lwb_r};
        vme_out_pkg::OFF_SWB:    REG_RDATA <= {26'h0, swb_r};
        vme_out_pkg::OFF_ICR:    REG_RDATA <= {24'h0, icr_r};
        vme_out_pkg::OFF_AMSR:   REG_RDATA <= {26'h0, amsr_r};
        vme_out_pkg::OFF_BESR:   REG_RDATA <= {31'h0, besr_err_r};
        vme_out_pkg::OFF_PIC:    REG_RDATA <= {31'h0, pic_en_r};
        vme_out_pkg::OFF_BTC:    REG_RDATA <= {24'h0, btc_r};
        vme_out_pkg::OFF_BDR:    REG_RDATA <= {24'h0, bdr_r};
        vme_out_pkg::OFF_LEN_LO: REG_RDATA <= {24'h0, len_lo_r};
        vme_out_pkg::OFF_LEN_HI: REG_RDATA <= {24'h0, len_hi_r};
        vme_out_pkg::OFF_DIC:    REG_RDATA <= {31'h0, dic_en_r};
        vme_out_pkg::OFF_DSTAT:  REG_RDATA <= {30'h0, DMA_BUSY, dma_done_r};
        default:                 REG_RDATA <= 32'h0;
      endcase
    end
  end
  // ==========================================================
  // Block engine
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      state_r   <= vme_out_pkg::S_IDLE;
      dma_va_r  <= 32'h0;
      dma_pa_r  <= 32'h0;
      dma_rem_r <= 16'h0;
      dma_am_r  <= 6'h00;
      dma_rd_r  <= 1'b0;
      dma_d64_r <= 1'b0;
      dma_big_r <= 1'b0;
      gap_r     <= 9'h000;
    end else begin
      case (state_r)
        vme_out_pkg::S_IDLE: begin
          if (dma_go) begin
            dma_va_r  <= vaddr;
            dma_pa_r  <= PCI_WDATA;
            dma_rem_r <= {len_hi_r, len_lo_r[7:1], 1'b0};
            dma_am_r  <= am_of(entry[1:0], entry[3:2], 1'b1, bdr_r[vme_out_pkg::BDR_D64],
                               amsr_r);
            dma_rd_r  <= btc_r[vme_out_pkg::BTC_DIR];
            dma_d64_r <= bdr_r[vme_out_pkg::BDR_D64];
            dma_big_r <= bdr_r[vme_out_pkg::BDR_D64] && bdr_r[vme_out_pkg::BDR_X2K];
            state_r   <= vme_out_pkg::S_ISSUE;
          end
        end
        vme_out_pkg::S_ISSUE: begin
          dma_va_r  <= dma_va_r + {16'h0, chunk};
          dma_pa_r  <= dma_pa_r + {16'h0, chunk};
          dma_rem_r <= dma_rem_r - chunk;
          state_r   <= (dma_rem_r == 16'h0) ? vme_out_pkg::S_IDLE : vme_out_pkg::S_TEN;
        end
        vme_out_pkg::S_TEN: begin
          if (VME_DONE) begin
            // Gap lets inbound slave traffic win the bus between tenures
            gap_r   <= 9'(btc_r[3:0]) * 9'(vme_out_pkg::ILV_CYCLES) - 9'h001;
            if (dma_rem_r == 16'h0)
              state_r <= vme_out_pkg::S_IDLE;
            else if (btc_r[3:0] == 4'h0)
              state_r <= vme_out_pkg::S_ISSUE;
            else
              state_r <= vme_out_pkg::S_GAP;
          end
        end
        vme_out_pkg::S_GAP: begin
          gap_r <= gap_r - 9'h001;
          if (gap_r == 9'h000)
            state_r <= vme_out_pkg::S_ISSUE;
        end
        default: state_r <= vme_out_pkg::S_IDLE;
      endcase
    end
  end
  // ==========================================================
  // Command out
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      PCI_CLAIM <= 1'b0;
      PCI_ERR   <= 1'b0;
      VME_START <= 1'b0;
      VME_HOLD  <= 1'b0;
      VME_CMD   <= '0;
    end else begin
      PCI_CLAIM <= take;
      PCI_ERR   <= take && !entry[vme_out_pkg::E_VALID];
      VME_START <= single_go || (state_r == vme_out_pkg::S_ISSUE && dma_rem_r != 16'h0);
      if (single_go) begin
        VME_HOLD <= entry[vme_out_pkg::E_LOCK] && icr_r[7:5] == vme_out_pkg::LOCK_ENABLE;
        VME_CMD  <= '{addr: vaddr, am: am_of(entry[1:0], entry[3:2], 1'b0, 1'b0, amsr_r),
                      dsize: dsize_of(PCI_BE), write: PCI_WRITE, block: 1'b0,
                      len: 16'h0, pci_addr: PCI_ADDR};
      end else if (state_r == vme_out_pkg::S_ISSUE && dma_rem_r != 16'h0) begin
        VME_CMD  <= '{addr: dma_va_r, am: dma_am_r,
                      dsize: dma_d64_r ? vme_out_pkg::DS_D64 : vme_out_pkg::DS_D32,
                      write: !dma_rd_r, block: 1'b1, len: chunk, pci_addr: dma_pa_r};
      end
    end
  end
  // ==========================================================
  // Checks
  property p_claim;
    @(posedge CLK) disable iff (!RST_N) take |=> PCI_CLAIM;
  endproperty
  a_claim: assert property (p_claim) else $error("window hit not claimed");
  property p_noclaim;
    @(posedge CLK) disable iff (!RST_N)
      (PCI_REQ && !hit1 && !hit2) |=> !PCI_CLAIM && (!VME_START || VME_CMD.block);
  endproperty
  a_noclaim: assert property (p_noclaim) else $error("miss was claimed");
  property p_page;
    @(posedge CLK) disable iff (!RST_N)
      single_go |=> VME_CMD.addr[31:18] == $past(entry[31:18])
                    && VME_CMD.addr[17:2] == $past(PCI_ADDR[17:2]);
  endproperty
  a_page: assert property (p_page) else $error("vme address wrong");
  property p_inval;
    @(posedge CLK) disable iff (!RST_N)
      (take && !entry[vme_out_pkg::E_VALID]) |=> PCI_ERR && !VME_START && besr_err_r;
  endproperty
  a_inval: assert property (p_inval) else $error("invalid entry not flagged");
  property p_irq;
    @(posedge CLK) disable iff (!RST_N) ERR_IRQ |-> $past(pic_en_r) && $past(besr_err_r);
  endproperty
  a_irq: assert property (p_irq) else $error("error irq without enable");
  property p_am32;
    @(posedge CLK) disable iff (!RST_N)
      (single_go && entry[3:0] == 4'h1) |=> VME_CMD.am == 6'h09;
  endproperty
  a_am32: assert property (p_am32) else $error("A32 user data code wrong");
  property p_hold;
    @(posedge CLK) disable iff (!RST_N)
      (single_go && entry[vme_out_pkg::E_LOCK] && icr_r[7:5] == 3'h0) |=> !VME_HOLD;
  endproperty
  a_hold: assert property (p_hold) else $error("lock held while disabled");
  property p_span;
    @(posedge CLK) disable iff (!RST_N)
      (VME_START && VME_CMD.block) |-> ({5'h0, VME_CMD.addr[10:0]} + VME_CMD.len) <= 16'h0800
                                       && VME_CMD.len != 16'h0;
  endproperty
  a_span: assert property (p_span) else $error("tenure crosses boundary");
  property p_gap;
    @(posedge CLK) disable iff (!RST_N)
      (state_r == vme_out_pkg::S_TEN && VME_DONE && dma_rem_r != 16'h0 && btc_r[3:0] == 4'h1)
      |=> !VME_START [*8];
  endproperty
  a_gap: assert property (p_gap) else $error("interleave gap too short");
  property p_dir;
    @(posedge CLK) disable iff (!RST_N)
      (VME_START && VME_CMD.block) |-> VME_CMD.write == !dma_rd_r;
  endproperty
  a_dir: assert property (p_dir) else $error("dma direction wrong");
  c_single: cover property (@(posedge CLK) disable iff (!RST_N) single_go ##1 VME_START);
  c_dma:    cover property (@(posedge CLK) disable iff (!RST_N) dma_go ##[1:200] dma_end);
  c_gap:    cover property (@(posedge CLK) disable iff (!RST_N) state_r == vme_out_pkg::S_GAP);
  c_lock:   cover property (@(posedge CLK) disable iff (!RST_N) VME_HOLD ##[1:20] !VME_HOLD);
endmodule
`default_nettype wire

// file: dv/vme_slave_model.sv
`timescale 1ns/1ps
`default_nettype none
module vme_slave_model #(
  parameter int DLY = 4
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic start,
  input  wire logic block,
  output logic      done
);
  // ==========================================================
  // Tenure end after a fixed delay; a long DLY mimics a slow slave
  int cnt_r;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_r <= 0;
      done  <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start && block) begin
        cnt_r <= DLY;
      end else if (cnt_r > 1) begin
        cnt_r <= cnt_r - 1;
      end else if (cnt_r == 1) begin
        cnt_r <= 0;
        done  <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// file: dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) \
  begin \
    checks_done++; \
    if ((got) !== (exp)) begin \
      miscompares++; \
      $display("wrong value %s expected %0h seen %0h", nm, exp, got); \
    end \
  end
module tb;
  // ==========================================================
  // Signals
  logic                  clk = 1'b0;
  logic                  rst_n = 1'b0;
  logic [13:0]           reg_addr = 14'h0000;
  logic [31:0]           reg_wdata = 32'h0;
  logic                  reg_wr = 1'b0;
  logic                  reg_rd = 1'b0;
  logic [31:0]           reg_rdata;
  logic                  pci_req = 1'b0;
  logic [31:0]           pci_addr = 32'h0;
  logic [3:0]            pci_be = 4'h0;
  logic                  pci_write = 1'b0;
  logic [31:0]           pci_wdata = 32'h0;
  logic                  pci_claim;
  logic                  pci_err;
  logic                  vme_start;
  vme_out_pkg::vme_cmd_t vme_cmd;
  logic                  vme_done;
  logic                  vme_hold;
  logic                  err_irq;
  logic                  dma_irq;
  logic                  dma_busy;
  int                    miscompares = 0;
  int                    checks_done = 0;
  int                    cyc = 0;
  int                    tstart[$];
  int                    tdone[$];
  vme_out_pkg::vme_cmd_t tcmd[$];
  logic [31:0]           v;
  // Size, code, expected modifier
  logic [9:0]            amtab [9] = '{10'h109, 10'h14A, 10'h18D, 10'h1CE, 10'h339,
                                       10'h3FE, 10'h229, 10'h2AD, 10'h015};
  // Enables, size, low address bits
  logic [7:0]            betab [4] = '{8'h34, 8'hC6, 8'hF8, 8'h83};

  always #5 clk = ~clk;

  vme_outbound_bridge DUT (
    .CLK(clk), .RST_N(rst_n), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
    .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .PCI_REQ(pci_req),
    .PCI_ADDR(pci_addr), .PCI_BE(pci_be), .PCI_WRITE(pci_write), .PCI_WDATA(pci_wdata),
    .PCI_CLAIM(pci_claim), .PCI_ERR(pci_err), .VME_START(vme_start), .VME_CMD(vme_cmd),
    .VME_DONE(vme_done), .VME_HOLD(vme_hold), .ERR_IRQ(err_irq), .DMA_IRQ(dma_irq),
    .DMA_BUSY(dma_busy)
  );

  vme_slave_model #(.DLY(6)) slave (
    .clk(clk), .rst_n(rst_n), .start(vme_start), .block(vme_cmd.block), .done(vme_done)
  );

  // ==========================================================
  // Tenure log, both events seen at the same edge phase
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (vme_start === 1'b1 && vme_cmd.block === 1'b1) begin
      tcmd.push_back(vme_cmd);
      tstart.push_back(cyc);
    end
    if (vme_done === 1'b1) begin
      tdone.push_back(cyc);
    end
  end

  // ==========================================================
  // Access tasks
  function automatic logic [13:0] sg(input int i);
    return vme_out_pkg::OFF_SG + 14'(i * 4);
  endfunction

  function automatic logic [31:0] ent(input logic [13:0] pg, input logic lk,
                                      input logic [1:0] fc, input logic [1:0] sz);
    return {pg, 12'h000, 1'b1, lk, fc, sz};
  endfunction

  task automatic wr(input logic [13:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [13:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic pci(input logic [31:0] a, input logic [3:0] be, input logic w,
                     input logic [31:0] d);
    @(posedge clk);
    pci_req <= 1'b1;
    pci_addr <= a;
    pci_be <= be;
    pci_write <= w;
    pci_wdata <= d;
    @(posedge clk);
    pci_req <= 1'b0;
    #1;
  endtask

  task automatic single(input logic [31:0] a, input logic [3:0] be, input logic [31:0] ea,
                        input logic [5:0] am, input logic [1:0] ds);
    pci(a, be, 1'b0, 32'h0);
    `CHK("claim", 1'b1, pci_claim);
    `CHK("start", 1'b1, vme_start);
    `CHK("addr", ea, vme_cmd.addr);
    `CHK("am", am, vme_cmd.am);
    `CHK("dsize", ds, vme_cmd.dsize);
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ==========================================================
  // Watchdog, far above the few hundred cycles the tests need
  initial begin
    #300000;
    miscompares++;
    close_out();
  end

  // ==========================================================
  // Tests
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    rd(vme_out_pkg::OFF_BTC, v);
    `CHK("btc_reset", 32'h0000_0000, v);
    wr(vme_out_pkg::OFF_BTC, 32'h0000_00FF);
    rd(vme_out_pkg::OFF_BTC, v);
    `CHK("btc_bits", 32'h0000_005F, v);
    rd(14'h0030, v);
    `CHK("unmapped", 32'h0000_0000, v);
    wr(vme_out_pkg::OFF_BTC, 32'h0);
    wr(vme_out_pkg::OFF_LWB, 32'h2);
    wr(vme_out_pkg::OFF_SWB, 32'h3F);
    wr(vme_out_pkg::OFF_AMSR, 32'h15);
    for (int k = 0; k < 9; k++) begin
      wr(sg(1), ent(14'h1111, 1'b0, amtab[k][7:6], amtab[k][9:8]));
      single(32'h4004_0124, 4'h4, {14'h1111, 16'h0049, 2'h2}, amtab[k][5:0], 2'h0);
    end
    for (int k = 0; k < 4; k++) begin
      single(32'h4004_0000, betab[k][7:4], {14'h1111, 16'h0, betab[k][1:0]}, 6'h15,
             betab[k][3:2]);
    end
    wr(sg(257), ent(14'h2222, 1'b0, 2'h0, 2'h1));
    wr(sg(1), ent(14'h1111, 1'b0, 2'h0, 2'h1));
    single(32'h4404_0000, 4'hF, {14'h2222, 18'h0}, 6'h09, 2'h2);
    single(32'hFC04_0000, 4'hF, {14'h1111, 18'h0}, 6'h09, 2'h2);
    pci(32'h2004_0000, 4'hF, 1'b0, 32'h0);
    `CHK("miss_claim", 1'b0, pci_claim);
    `CHK("miss_start", 1'b0, vme_start);
    wr(sg(2), 32'h0);
    pci(32'h4008_0000, 4'hF, 1'b0, 32'h0);
    `CHK("inv_err", 1'b1, pci_err);
    `CHK("inv_start", 1'b0, vme_start);
    rd(vme_out_pkg::OFF_BESR, v);
    `CHK("besr", 1'b1, v[0]);
    `CHK("irq_masked", 1'b0, err_irq);
    wr(vme_out_pkg::OFF_PIC, 32'h1);
    repeat (2) @(posedge clk);
    `CHK("irq_on", 1'b1, err_irq);
    wr(vme_out_pkg::OFF_BESR, 32'h1);
    repeat (2) @(posedge clk);
    `CHK("irq_clr", 1'b0, err_irq);
    wr(vme_out_pkg::OFF_PIC, 32'h0);
    wr(vme_out_pkg::OFF_ICR, 32'h20);
    wr(sg(3), ent(14'h3333, 1'b1, 2'h0, 2'h1));
    pci(32'h400C_0000, 4'hF, 1'b0, 32'h0);
    `CHK("hold_on", 1'b1, vme_hold);
    pci(32'h4004_0000, 4'hF, 1'b0, 32'h0);
    `CHK("hold_next", 1'b0, vme_hold);
    wr(vme_out_pkg::OFF_ICR, 32'h0);
    pci(32'h400C_0000, 4'hF, 1'b0, 32'h0);
    `CHK("hold_off", 1'b0, vme_hold);
    // Block write of 0x180 bytes from mid-line, one-unit interleave
    wr(vme_out_pkg::OFF_LEN_LO, 32'h80);
    wr(vme_out_pkg::OFF_LEN_HI, 32'h01);
    wr(vme_out_pkg::OFF_BTC, 32'h41);
    pci(32'h4004_0080, 4'hF, 1'b1, 32'h0001_0000);
    wr(vme_out_pkg::OFF_BTC, 32'h01);
    for (int i = 0; i < 1000 && (dma_busy !== 1'b0 || tdone.size() < 2); i++) begin
      @(posedge clk);
    end
    `CHK("tenures", 2, tcmd.size());
    `CHK("t0_addr", {14'h1111, 18'h00080}, tcmd[0].addr);
    `CHK("t0_len", 16'h0080, tcmd[0].len);
    `CHK("t0_am", 6'h0B, tcmd[0].am);
    `CHK("t0_write", 1'b1, tcmd[0].write);
    `CHK("t0_dsize", 2'h2, tcmd[0].dsize);
    `CHK("t1_addr", {14'h1111, 18'h00100}, tcmd[1].addr);
    `CHK("t1_len", 16'h0100, tcmd[1].len);
    `CHK("t1_pci", 32'h0001_0080, tcmd[1].pci_addr);
    `CHK("gap", 27, tstart[1] - tdone[0]);
    rd(vme_out_pkg::OFF_DSTAT, v);
    `CHK("dma_done", 1'b1, v[0]);
    wr(vme_out_pkg::OFF_DIC, 32'h1);
    repeat (2) @(posedge clk);
    `CHK("dma_irq", 1'b1, dma_irq);
    // D64 read on 2 KB lines, odd length forced even, no interleave
    wr(vme_out_pkg::OFF_DSTAT, 32'h1);
    wr(vme_out_pkg::OFF_BDR, 32'h90);
    wr(vme_out_pkg::OFF_LEN_LO, 32'h01);
    wr(vme_out_pkg::OFF_LEN_HI, 32'h0A);
    wr(vme_out_pkg::OFF_BTC, 32'h50);
    pci(32'h4004_0800, 4'hF, 1'b1, 32'h0002_0000);
    wr(vme_out_pkg::OFF_BTC, 32'h10);
    for (int i = 0; i < 1000 && (dma_busy !== 1'b0 || tdone.size() < 4); i++) begin
      @(posedge clk);
    end
    `CHK("tenures2", 4, tcmd.size());
    `CHK("t2_addr", {14'h1111, 18'h00800}, tcmd[2].addr);
    `CHK("t2_len", 16'h0800, tcmd[2].len);
    `CHK("t2_am", 6'h08, tcmd[2].am);
    `CHK("t2_write", 1'b0, tcmd[2].write);
    `CHK("t2_dsize", 2'h3, tcmd[2].dsize);
    `CHK("t3_len", 16'h0200, tcmd[3].len);
    `CHK("t3_pci", 32'h0002_0800, tcmd[3].pci_addr);
    `CHK("gap0", 2, tstart[3] - tdone[2]);
    rd(vme_out_pkg::OFF_DSTAT, v);
    `CHK("dma_done2", 32'h0000_0001, v);
    close_out();
  end
endmodule
`default_nettype wire
